/* File: rtl/stp_pkg.sv */
// streaming tape host port: shared constants and carrier types
// assumes one 10 MHz clock and programmed i/o strobes one cycle wide
package stp_pkg;
    localparam logic [5:0] DEV_CODE_FIRST = 6'o60;  // first pio code
    localparam logic [5:0] DEV_CODE_LAST  = 6'o63;  // last pio code
    localparam logic [5:0] DEV_CODE_DMA   = 6'o77;  // data channel code
    localparam int         BYTE_W         = 8;      // bus byte width
    localparam int         FIFO_DEPTH     = 32;     // data buffer depth
    // status word bit positions, numbered from the lsb (lsb is bit 0)
    localparam int         STAT_DIR_POS   = 7;      // direction, 1 = input
    localparam int         STAT_ACK_POS   = 3;      // acknowledge
    localparam int         STAT_EXC_POS   = 1;      // exception
    localparam int         STAT_RDY_POS   = 0;      // ready
    // control word bit positions, numbered from the lsb
    localparam int         CTL_ONLINE_POS = 0;      // go on line
    localparam int         CTL_REQ_POS    = 1;      // raise request
    localparam int         CTL_RST_POS    = 2;      // interface reset
    localparam int         CTL_CMD_POS    = 3;      // send byte from ac
    localparam int         CTL_XFER_POS   = 4;      // data mode, 1 = write
    localparam int         CTL_RUN_POS    = 5;      // enable data channel
    localparam logic [15:0] STATUS_RESET  = 16'h0000; // status idle value
    localparam int         RST_TIME_NS    = 25000;  // interface reset pulse
    localparam int         CLK_PERIOD_NS  = 100;    // i_clock period
    localparam int         RST_CYCLES     =
        (RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] RST_CNT_INIT  = RST_CYCLES[15:0];

    // one byte with its parity as it crosses the tape bus
    typedef struct packed {
        logic              par;    // odd parity bit
        logic [BYTE_W-1:0] data;   // byte, bit 7 msb
    } stp_byte_s;
endpackage : stp_pkg

/* File: rtl/stp_fifo.sv */
// stp_fifo: synchronous first-in first-out buffer with valid/ready
// assumes a single clock; full and empty are honest at every cycle
`timescale 1ns/1ps
`default_nettype none
module stp_fifo #(
    parameter int WIDTH = 9,   // word width
    parameter int DEPTH = 32   // word count, power of two
) (
    input  wire logic             i_clock,    // system clock
    input  wire logic             i_sys_rst,  // async reset, high
    input  wire logic             i_clear,    // flush contents
    input  wire logic [WIDTH-1:0] i_data,     // word to store
    input  wire logic             i_valid,    // word offered
    output logic                  o_ready,    // room for a word
    output logic      [WIDTH-1:0] o_data,     // oldest word
    output logic                  o_valid,    // oldest word present
    input  wire logic             i_ready     // drain side takes it
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];       // storage array
    logic [AW:0]      wr_ptr;            // write pointer, extra wrap bit
    logic [AW:0]      rd_ptr;            // read pointer, extra wrap bit
    logic             push;              // word accepted
    logic             pop;               // word removed

    // wrap bits differ with equal index means full
    assign o_ready = !((wr_ptr[AW] != rd_ptr[AW]) &&
                       (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    assign o_valid = (wr_ptr != rd_ptr);
    assign push    = i_valid && o_ready;
    assign pop     = i_ready && o_valid;
    assign o_data  = mem[rd_ptr[AW-1:0]];

    // storage has no reset: contents are guarded by the pointers
    always_ff @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end

    // pointer bookkeeping
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (i_clear) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : stp_fifo
`default_nettype wire

/* File: rtl/stp_host_port.sv */
// stp_host_port: processor side controller for one streaming tape drive
// assumes pio strobes qualified by a 6-bit device code, a data channel
// that asks for words, and tape bus pins already synchronous to i_clock
`timescale 1ns/1ps
`default_nettype none
module stp_host_port
    import stp_pkg::*;
(
    input  wire logic        i_clock,                // 10 MHz clock
    input  wire logic        i_sys_rst,              // async reset, high
    // processor programmed i/o
    input  wire logic [5:0]  i_dev_code,             // device code
    input  wire logic        i_status_read_instr,    // status read strobe
    input  wire logic        i_control_write_instr,  // control write strobe
    input  wire logic [15:0] i_ac,                   // accumulator out
    output logic      [15:0] o_status,               // status word
    // data channel
    input  wire logic        i_dma_output_transfer,  // word to tape
    input  wire logic        i_dma_input_transfer,   // word from tape
    input  wire logic [7:0]  i_dma_data,             // byte to tape
    output logic      [7:0]  o_dma_data,             // byte from tape
    output logic             o_dma_request,          // channel wanted
    // tape bus, active low; bus pins split into in, out and enable
    input  wire logic [7:0]  i_bus_n,                // bus level in
    output logic      [7:0]  o_bus_n,                // bus drive value
    input  wire logic        i_bus_odd_parity_n,     // parity level in
    output logic             o_bus_odd_parity_n,     // parity drive value
    output logic             o_bus_oe,               // we drive the bus
    output logic             o_online_n,             // on line
    output logic             o_request_n,            // request
    output logic             o_reset_n,              // interface reset
    output logic             o_byte_strobe_n,        // transfer
    input  wire logic        i_ack_n,                // acknowledge
    input  wire logic        i_ready_n,              // ready
    input  wire logic        i_drive_exception_n,    // exception
    input  wire logic        i_direction_n           // low = to host
);
    typedef enum {ST_IDLE, ST_DRIVE, ST_WAIT_ACK, ST_WAIT_REL} stp_state_e;
    stp_state_e state;                 // bus handshake state
    logic       online;                // on line to the drive
    logic       request;               // request held
    logic       write_mode;            // data flows to tape
    logic       run;                   // data channel enabled
    logic [15:0] rst_cnt;              // interface reset countdown
    stp_byte_s  out_byte;              // byte held on the bus
    logic       cmd_pend;              // command byte waiting
    logic [7:0] cmd_byte;              // command byte from ac
    logic       pio_hit;               // instruction aimed at us
    logic       dma_hit;               // channel aimed at us
    logic       ctl_wr;                // control write accepted
    logic       drv_rdy;               // drive ready, true sense
    logic       drv_exc;               // drive exception, true sense
    logic       drv_ack;               // drive ack, true sense
    logic       to_host;               // drive drives the bus
    // fifo plumbing
    stp_byte_s  wf_in;                 // word into the fifo
    logic       wf_in_valid;           // fifo fill strobe
    logic       wf_in_ready;           // fifo has room
    stp_byte_s  wf_out;                // oldest fifo word
    logic       wf_out_valid;          // fifo not empty
    logic       wf_out_ready;          // fifo drain strobe

    // true-sense versions of the active-low lines
    assign drv_rdy = !i_ready_n;
    assign drv_exc = !i_drive_exception_n;
    assign drv_ack = !i_ack_n;
    assign to_host = !i_direction_n;

    // device code decode for pio and the data channel
    assign pio_hit = (i_dev_code >= DEV_CODE_FIRST) &&
                     (i_dev_code <= DEV_CODE_LAST);
    assign dma_hit = (i_dev_code == DEV_CODE_DMA);
    assign ctl_wr  = i_control_write_instr && pio_hit;

    // status word, reserved bits read zero; registered for the data bus
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_status <= STATUS_RESET;
        end else if (i_status_read_instr && pio_hit) begin
            o_status <= STATUS_RESET;
            o_status[STAT_DIR_POS] <= to_host;
            o_status[STAT_ACK_POS] <= drv_ack;
            o_status[STAT_EXC_POS] <= drv_exc;
            o_status[STAT_RDY_POS] <= drv_rdy;
        end
    end

    // control bits written by software
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            online     <= 1'b0;
            write_mode <= 1'b0;
            run        <= 1'b0;
        end else if (ctl_wr) begin
            online     <= i_ac[CTL_ONLINE_POS];
            write_mode <= i_ac[CTL_XFER_POS];
            run        <= i_ac[CTL_RUN_POS];
        end
    end

    // request is raised only while the drive shows ready or exception;
    // it drops on the first acknowledge so the drive sees one sequence
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            request <= 1'b0;
        end else if (rst_cnt != 16'h0000) begin
            request <= 1'b0;
        end else if (ctl_wr && i_ac[CTL_REQ_POS] && (drv_rdy || drv_exc)) begin
            request <= 1'b1;
        end else if (drv_ack || (ctl_wr && !i_ac[CTL_REQ_POS])) begin
            request <= 1'b0;
        end
    end

    // interface reset pulse of fixed length; the drive answers it with
    // exception, which software sees in the status word
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rst_cnt <= 16'h0000;
        end else if (ctl_wr && i_ac[CTL_RST_POS]) begin
            rst_cnt <= RST_CNT_INIT;
        end else if (rst_cnt != 16'h0000) begin
            rst_cnt <= rst_cnt - 16'h0001;
        end
    end

    // a command byte from the accumulator waits for the bus
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cmd_pend <= 1'b0;
            cmd_byte <= 8'h00;
        end else if (ctl_wr && i_ac[CTL_CMD_POS]) begin
            cmd_pend <= 1'b1;
            cmd_byte <= i_ac[15:8];
        end else if (state == ST_IDLE && cmd_pend && !to_host &&
                     rst_cnt == 16'h0000) begin
            // held through an interface reset so the byte is not lost
            cmd_pend <= 1'b0;
        end
    end

    // fifo fill side: outgoing words from the channel, incoming bytes
    // from the tape bus; the channel only asks while there is room
    always_comb begin
        wf_in       = '0;
        wf_in_valid = 1'b0;
        if (write_mode) begin
            wf_in.data  = i_dma_data;
            wf_in.par   = ~^i_dma_data;
            wf_in_valid = i_dma_output_transfer && dma_hit;
        end else begin
            wf_in.data  = ~i_bus_n;
            wf_in.par   = ~i_bus_odd_parity_n;
            wf_in_valid = to_host && drv_ack && state == ST_IDLE && run;
        end
    end

    // fifo drain side
    always_comb begin
        if (write_mode) begin
            wf_out_ready = (state == ST_IDLE) && !cmd_pend && run &&
                           !to_host && (rst_cnt == 16'h0000);
        end else begin
            wf_out_ready = i_dma_input_transfer && dma_hit;
        end
    end

    // data channel request: room to fill when writing, data when reading
    assign o_dma_request = run && (write_mode ? wf_in_ready : wf_out_valid);

    // byte returned to the channel is captured into a flip-flop
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dma_data <= 8'h00;
        end else if (!write_mode && wf_out_ready && wf_out_valid) begin
            o_dma_data <= wf_out.data;
        end
    end

    // outgoing handshake: set bus, strobe, hold until ack, wait release
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state    <= ST_IDLE;
            out_byte <= '0;
        end else if (rst_cnt != 16'h0000) begin
            state    <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmd_pend && !to_host) begin
                        out_byte.data <= cmd_byte;
                        out_byte.par  <= ~^cmd_byte;
                        state         <= ST_DRIVE;
                    end else if (write_mode && wf_out_ready &&
                                 wf_out_valid) begin
                        // a channel pop in read mode must not start
                        // an outgoing strobe on a bus the drive owns
                        out_byte <= wf_out;
                        state    <= ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    state <= ST_WAIT_ACK;  // one cycle of setup
                end
                ST_WAIT_ACK: begin
                    if (drv_ack) begin
                        state <= ST_WAIT_REL;
                    end
                end
                ST_WAIT_REL: begin
                    if (!drv_ack) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // the byte stays on the bus through the strobe until ack drops
    assign o_bus_oe           = (state != ST_IDLE) && !to_host;
    assign o_bus_n            = ~out_byte.data;
    assign o_bus_odd_parity_n = ~out_byte.par;
    assign o_byte_strobe_n    = !(state == ST_WAIT_ACK);
    assign o_online_n         = !online;
    assign o_request_n        = !request;
    assign o_reset_n          = (rst_cnt == 16'h0000);

    stp_fifo #(
        .WIDTH ($bits(stp_byte_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock   (i_clock),
        .i_sys_rst (i_sys_rst),
        .i_clear   (ctl_wr),
        .i_data    (wf_in),
        .i_valid   (wf_in_valid),
        .o_ready   (wf_in_ready),
        .o_data    (wf_out),
        .o_valid   (wf_out_valid),
        .i_ready   (wf_out_ready)
    );
endmodule : stp_host_port
`default_nettype wire

/* File: test/stp_host_port_checker.sv */
// checker: pin timing of the tape host port
// assumes a bind onto stp_host_port and a single clock
`timescale 1ns/1ps
`default_nettype none
module stp_host_port_checker
    import stp_pkg::*;
(
    input wire logic        i_clock,
    input wire logic        i_sys_rst,
    input wire logic [5:0]  i_dev_code,
    input wire logic        i_status_read_instr,
    input wire logic        i_control_write_instr,
    input wire logic [15:0] i_ac,
    input wire logic [15:0] o_status,
    input wire logic [7:0]  o_bus_n,
    input wire logic        o_bus_odd_parity_n,
    input wire logic        o_bus_oe,
    input wire logic        o_online_n,
    input wire logic        o_request_n,
    input wire logic        o_reset_n,
    input wire logic        o_byte_strobe_n,
    input wire logic        i_ack_n,
    input wire logic        i_ready_n,
    input wire logic        i_drive_exception_n,
    input wire logic        i_direction_n
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_sys_rst);
    logic       pio;     // strobe aimed at this port
    logic [8:0] rst_lo;  // cycles the interface reset has been low
    assign pio = (i_dev_code >= DEV_CODE_FIRST) &&
                 (i_dev_code <= DEV_CODE_LAST);
    // count the reset pulse; a short pulse may leave the drive half set
    always_ff @(posedge i_clock or posedge i_sys_rst) begin
        if (i_sys_rst)
            rst_lo <= 9'h000;
        else if (!o_reset_n)
            rst_lo <= rst_lo + 9'h001;
        else
            rst_lo <= 9'h000;
    end
    property p_status;
        i_status_read_instr && pio |=> o_status == {8'h00,
            !$past(i_direction_n), 3'b000, !$past(i_ack_n), 1'b0,
            !$past(i_drive_exception_n), !$past(i_ready_n)};
    endproperty
    a_status: assert property (p_status)
        else $error("status word wrong");
    property p_online;
        i_control_write_instr && pio |=> o_online_n == !$past(i_ac[0]);
    endproperty
    a_online: assert property (p_online)
        else $error("online line wrong");
    property p_foreign;
        i_control_write_instr && !pio |=> $stable(o_online_n);
    endproperty
    a_foreign: assert property (p_foreign)
        else $error("foreign code obeyed");
    property p_req_gate;
        $fell(o_request_n) |-> !$past(i_ready_n) ||
            !$past(i_drive_exception_n);
    endproperty
    a_req_gate: assert property (p_req_gate)
        else $error("request without ready");
    property p_strobe_oe;
        !o_byte_strobe_n |-> o_bus_oe;
    endproperty
    a_strobe_oe: assert property (p_strobe_oe)
        else $error("strobe with bus released");
    property p_hold;
        !o_byte_strobe_n [*2] |-> $stable(o_bus_n) &&
            $stable(o_bus_odd_parity_n);
    endproperty
    a_hold: assert property (p_hold)
        else $error("byte moved under strobe");
    property p_parity;
        o_bus_oe |-> ^{o_bus_n, o_bus_odd_parity_n} == 1'b0;
    endproperty
    a_parity: assert property (p_parity)
        else $error("parity not odd");
    property p_release;
        !o_byte_strobe_n && !i_ack_n |-> ##[1:2] o_byte_strobe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("strobe kept after ack");
    property p_rst_len;
        $rose(o_reset_n) |-> rst_lo == RST_CNT_INIT[8:0];
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("reset pulse length wrong");
    c_byte: cover property (!o_byte_strobe_n && !i_ack_n);
    c_reset: cover property ($rose(o_reset_n));
    c_read: cover property (i_status_read_instr && pio);
endmodule : stp_host_port_checker
bind stp_host_port stp_host_port_checker u_stp_host_port_checker (
    .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_dev_code(i_dev_code),
    .i_status_read_instr(i_status_read_instr), .i_ac(i_ac),
    .i_control_write_instr(i_control_write_instr), .o_status(o_status),
    .o_bus_n(o_bus_n), .o_bus_odd_parity_n(o_bus_odd_parity_n),
    .o_bus_oe(o_bus_oe), .o_online_n(o_online_n), .i_ack_n(i_ack_n),
    .o_request_n(o_request_n), .o_reset_n(o_reset_n),
    .o_byte_strobe_n(o_byte_strobe_n), .i_ready_n(i_ready_n),
    .i_drive_exception_n(i_drive_exception_n),
    .i_direction_n(i_direction_n));
`default_nettype wire

/* File: test/stp_drive_model.sv */
// stp_drive_model: behavioural tape drive interface on the far side
// assumes the bench resolves the shared bus and drives stall controls
`timescale 1ns/1ps
`default_nettype none
module stp_drive_model (
    input  wire logic       i_clock,
    input  wire logic       i_reset_n,        // interface reset
    input  wire logic       i_request_n,
    input  wire logic       i_byte_strobe_n,
    input  wire logic [7:0] i_bus_n,          // resolved bus level
    input  wire logic       i_hold,           // stall acknowledges
    input  wire logic       i_to_host,        // bus turned to host
    input  wire logic       i_tx_go,          // send i_tx_byte
    input  wire logic [7:0] i_tx_byte,
    output logic      [7:0] o_bus_n,
    output logic            o_bus_odd_parity_n,
    output logic            o_ack_n,
    output logic            o_ready_n,
    output logic            o_exc_n,
    output logic            o_dir_n,
    output logic      [7:0] o_rx_byte,
    output logic            o_rx_stb
);
    logic pend;  // byte placed, ack pulse due
    assign o_dir_n = !i_to_host;
    initial begin
        {o_ack_n, o_exc_n, o_bus_n, o_bus_odd_parity_n} = '1;
        {o_ready_n, o_rx_stb, o_rx_byte, pend} = '0;
    end
    // one branch per cycle keeps the handshake strictly in order
    always @(posedge i_clock) begin
        o_rx_stb <= 1'b0;
        if (!i_reset_n) begin
            {o_ready_n, o_exc_n, o_ack_n, pend} <= 4'b1010;
        end else if (i_tx_go) begin
            o_bus_n <= ~i_tx_byte;
            o_bus_odd_parity_n <= ^i_tx_byte;
            pend <= 1'b1;
        end else if (pend) begin  // single ack pulse per byte
            o_ack_n <= 1'b0;
            pend <= 1'b0;
        end else if (!o_ack_n && i_to_host) begin
            o_ack_n <= 1'b1;
        end else if (o_ack_n && !i_hold &&
                     (!i_request_n || !i_byte_strobe_n)) begin
            {o_ack_n, o_exc_n, o_ready_n} <= 3'b010;
            o_rx_stb <= !i_byte_strobe_n;
            o_rx_byte <= ~i_bus_n;
        end else if (!o_ack_n && i_request_n && i_byte_strobe_n) begin
            o_ack_n <= 1'b1;
        end else begin  // bus not ours: a pattern that never settles
            o_bus_n <= ~o_bus_n;
            o_bus_odd_parity_n <= ~o_bus_odd_parity_n;
        end
    end
endmodule : stp_drive_model
`default_nettype wire

/* File: test/test_streaming_tape_host_port.sv */
// bench for the streaming tape host port against a drive model
// assumes the drive model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_streaming_tape_host_port;
    import stp_pkg::*;
    logic clk, rst, srd, cwr, dot, dit, oe, onl, req, rstn, stb, ack;
    logic rdy, exc, dir, par_o, par_m, hold, host, go, rd_pend, dq_v, rxs;
    logic [5:0]  dev;
    logic [15:0] ac, status;
    logic [7:0]  dd, dq, bus_o, bus_m, txb, rxb, b;
    logic [7:0]  tape_q[$], dma_q[$];  // expected bytes, oldest first
    int          err_count, n_checks, cycles, i, k;
    stp_host_port u_stp_host_port (
        .i_clock(clk), .i_sys_rst(rst), .i_dev_code(dev),
        .i_status_read_instr(srd), .i_control_write_instr(cwr),
        .i_ac(ac), .o_status(status), .i_dma_output_transfer(dot),
        .i_dma_input_transfer(dit), .i_dma_data(dd), .o_dma_data(dq),
        .o_dma_request(dq_v), .i_bus_n(oe ? bus_o : bus_m),
        .o_bus_n(bus_o), .i_bus_odd_parity_n(oe ? par_o : par_m),
        .o_bus_odd_parity_n(par_o), .o_bus_oe(oe), .o_online_n(onl),
        .o_request_n(req), .o_reset_n(rstn), .o_byte_strobe_n(stb),
        .i_ack_n(ack), .i_ready_n(rdy), .i_drive_exception_n(exc),
        .i_direction_n(dir));
    stp_drive_model u_stp_drive_model (
        .i_clock(clk), .i_reset_n(rstn), .i_request_n(req),
        .i_byte_strobe_n(stb), .i_bus_n(oe ? bus_o : bus_m),
        .i_hold(hold), .i_to_host(host), .i_tx_go(go), .i_tx_byte(txb),
        .o_bus_n(bus_m), .o_bus_odd_parity_n(par_m), .o_ack_n(ack),
        .o_ready_n(rdy), .o_exc_n(exc), .o_dir_n(dir), .o_rx_byte(rxb),
        .o_rx_stb(rxs));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic tick();
        @(posedge clk);
        #10;
    endtask : tick
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    // one programmed strobe, then a quiet cycle before the next one
    task automatic pio(input logic [5:0] c, input logic w,
                       input logic [15:0] v);
        {dev, ac, cwr, srd} = {c, v, w, !w};
        tick();
        {cwr, srd} = 2'b00;
        tick();
    endtask : pio
    task automatic drain();
        for (k = 0; k < 500 && tape_q.size() > 0; k++) tick();
    endtask : drain
    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // watcher: each result that shows up meets the oldest note
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin  // a hang counts as a mismatch
            err_count++;
            $display("[ERR] %0t timeout", $time);
            test_done();
        end
        if (rxs) check({8'h00, rxb}, {8'h00, tape_q.pop_front()});
        if (rd_pend) check({8'h00, dq}, {8'h00, dma_q.pop_front()});
        rd_pend <= 1'b0;
    end
    initial begin
        {srd, cwr, dot, dit, hold, host, go, rd_pend} = '0;
        {dev, ac, dd, txb} = {6'o60, 16'h0000, 8'h00, 8'h00};
        {err_count, n_checks, cycles} = '0;
        void'($urandom(73228));
        rst = 1'b1;
        repeat (8) @(posedge clk);
        #10 rst = 1'b0;
        pio(6'o64, 1'b1, 16'h0001);
        check(onl, 1'b1);
        pio(6'o60, 1'b1, 16'h0005);
        check(onl, 1'b0);
        repeat (RST_CYCLES + 4) tick();
        pio(6'o62, 1'b0, 16'h0000);
        check(status, 16'h0002);
        $display("test reset done");
        pio(6'o61, 1'b1, 16'h0003);
        repeat (6) tick();
        check(req, 1'b1);
        pio(6'o63, 1'b0, 16'h0000);
        check(status, 16'h0001);
        $display("test request done");
        for (i = 0; i < 6; i++) begin  // drive slow on odd bytes
            b = 8'($urandom);
            hold = i[0];
            tape_q.push_back(b);
            pio(6'o60, 1'b1, {b, 8'h09});
            repeat (5) tick();
            hold = 1'b0;
            drain();
        end
        $display("test command done");
        pio(6'o60, 1'b1, 16'h0031);
        {hold, dot, dd} = {2'b11, 8'h5a};  // foreign code, must be lost
        tick();
        {dot, dev} = {1'b0, DEV_CODE_DMA};
        for (i = 0; i < 40; i++) begin  // fill while the drive stalls
            {dot, dd} = {dq_v, 8'($urandom)};
            if (dq_v) tape_q.push_back(dd);
            tick();
        end
        dot = 1'b0;
        check(dq_v, 1'b0);
        hold = 1'b0;
        drain();
        $display("test buffer done");
        host = 1'b1;
        pio(6'o60, 1'b1, 16'h0021);
        pio(6'o62, 1'b0, 16'h0000);
        check(status, 16'h0081);
        for (i = 0; i < 4; i++) begin
            b = 8'($urandom);
            dma_q.push_back(b);
            {txb, go} = {b, 1'b1};
            tick();
            go = 1'b0;
            repeat (4) tick();
        end
        dev = DEV_CODE_DMA;
        for (i = 0; i < 4; i++) begin
            for (k = 0; k < 50 && dq_v !== 1'b1; k++) tick();
            dit = 1'b1;
            tick();
            {dit, rd_pend} = 2'b01;
            tick();
        end
        tick();
        $display("test input done");
        check(16'(tape_q.size() + dma_q.size()), 16'h0000);
        test_done();
    end
endmodule : test_streaming_tape_host_port
`default_nettype wire
